// >>> design/iop_pkg.sv
// Shared constants, layouts and types for the port configuration and data registers
package iop_pkg;

   // ************************************************************
   // Port set and per-port features
   // ************************************************************
   localparam int         IOP_PORTS      = 7;
   localparam int         IOP_W          = 8;
   localparam int         IOP_PORT_A     = 0;
   localparam int         IOP_PORT_B     = 1;
   localparam int         IOP_PORT_C     = 2;
   localparam int         IOP_PORT_D     = 3;
   localparam int         IOP_PORT_F     = 5;
   // One bit per port, bit 0 = port A ... bit 6 = port G
   localparam logic [6:0] IOP_HAS_FUNC   = 7'h70;
   localparam logic [6:0] IOP_HAS_OEPT   = 7'h27;
   localparam logic [6:0] IOP_HAS_SLEW   = 7'h24;
   localparam logic [6:0] IOP_HAS_OCELL  = 7'h03;
   localparam logic [6:0] IOP_HAS_ICELL  = 7'h07;
   localparam logic [6:0] IOP_HAS_OESTAT = 7'h27;
   localparam logic [7:0] IOP_D_PIN_MASK = 8'h0F;
   localparam logic [7:0] IOP_FULL_MASK  = 8'hFF;
   localparam logic [7:0] IOP_CFG_RST    = 8'h00;
   localparam logic [7:0] IOP_MASK_RST   = 8'h00;
   localparam logic [7:0] IOP_UNMAPPED   = 8'h00;

   // ************************************************************
   // Register kinds and address layout
   // ************************************************************
   localparam int IOP_RK_FUNC   = 0;
   localparam int IOP_RK_DIR    = 1;
   localparam int IOP_RK_DRIVE  = 2;
   localparam int IOP_RK_DIN    = 3;
   localparam int IOP_RK_DOUT   = 4;
   localparam int IOP_RK_OCELL  = 5;
   localparam int IOP_RK_MASK   = 6;
   localparam int IOP_RK_ICELL  = 7;
   localparam int IOP_RK_OESTAT = 8;
   localparam int IOP_NKINDS    = 9;
   // Offset address: [7] zero, [6:3] register kind code, [2:0] port
   localparam int IOP_KIND_LSB  = 3;
   localparam int IOP_KIND_MSB  = 6;
   localparam int IOP_PORT_MSB  = 2;
   localparam logic [8:0][3:0] IOP_KIND_OFS = {4'h8, 4'h7, 4'h6, 4'h5, 4'h4,
                                               4'h3, 4'h2, 4'h1, 4'h0};

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] func;
      logic [7:0] dir;
      logic [7:0] drive;
      logic [7:0] latch;
   } iop_port_cfg_t;

   typedef struct packed {
      logic       sel;
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iop_bus_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] open_drain;
      logic [7:0] fast_slew;
      logic [7:0] drive_on;
   } iop_pin_ctl_t;

   typedef struct packed {
      iop_port_cfg_t [6:0] cfg;
      logic [1:0][7:0]     mask;
      logic [7:0]          rdata;
      logic [1:0][7:0]     load;
      logic [7:0]          load_data;
   } iop_state_t;

   localparam iop_state_t IOP_STATE_RST = '0;

endpackage

// >>> design/iop_pin_drive.sv
// Pin driver control for one port: direction merge, mode select, drive type
`timescale 1ns/1ns
module iop_pin_drive #(
   parameter bit HAS_FUNC = 1'b0,
   parameter bit HAS_OEPT = 1'b0,
   parameter bit HAS_SLEW = 1'b0
) (
   input  iop_pkg::iop_port_cfg_t cfg,
   input  logic [7:0]             oe_term,
   input  logic [7:0]             addr_out,
   output iop_pkg::iop_pin_ctl_t  pin_ctl
);

   logic [7:0] mode_addr;
   logic [7:0] dir_eff;
   logic [7:0] dout;
   logic [7:0] odrain;

   always_comb begin
      mode_addr = HAS_FUNC ? cfg.func : 8'h00;
      dir_eff   = cfg.dir | (HAS_OEPT ? oe_term : 8'h00);
      dout      = (mode_addr & addr_out) | (~mode_addr & cfg.latch);
      odrain    = HAS_SLEW ? 8'h00 : cfg.drive;
      pin_ctl.out        = dout;
      pin_ctl.open_drain = odrain;
      pin_ctl.fast_slew  = HAS_SLEW ? cfg.drive : 8'h00;
      // Open drain pins only pull low; a high bit releases the pin
      pin_ctl.oe         = dir_eff & ~(odrain & dout);
      pin_ctl.drive_on   = dir_eff;
   end

endmodule

// >>> design/iop_port_regs.sv
// Port configuration and data registers for seven I/O ports on the MCU bus
`timescale 1ns/1ns
module iop_port_regs #(
   parameter logic [8:0][3:0] KIND_OFS = iop_pkg::IOP_KIND_OFS
) (
   input  logic                        mclk,
   input  logic                        rst_n,
   input  iop_pkg::iop_bus_req_t       bus_req,
   output logic [7:0]                  bus_rdata,
   input  logic [6:0][7:0]             pin_in,
   input  logic [6:0][7:0]             oe_term,
   input  logic [6:0][7:0]             addr_out,
   input  logic [1:0][7:0]             ocell_state,
   input  logic [2:0][7:0]             icell_state,
   output logic [1:0][7:0]             ocell_load,
   output logic [7:0]                  ocell_wdata,
   output iop_pkg::iop_pin_ctl_t [6:0] pin_ctl
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   generate
      for (genvar i = 0; i < iop_pkg::IOP_NKINDS; i++) begin : g_chk_i
         for (genvar j = i + 1; j < iop_pkg::IOP_NKINDS; j++) begin : g_chk_j
            if (KIND_OFS[i] == KIND_OFS[j]) begin : g_clash
               $error("Two register kinds share one offset");
            end
         end
      end
   endgenerate

   // ************************************************************
   // Decode helpers
   // ************************************************************
   function automatic bit port_has(input logic [6:0] set, input logic [2:0] port);
      bit r;
      r = 1'b0;
      if (port < 3'(iop_pkg::IOP_PORTS)) begin
         r = set[port];
      end
      return r;
   endfunction

   // Kind index for an offset, IOP_NKINDS when nothing matches
   function automatic int kind_of(input logic [7:0] addr);
      int k;
      k = iop_pkg::IOP_NKINDS;
      if (addr[7] == 1'b0) begin
         for (int i = 0; i < iop_pkg::IOP_NKINDS; i++) begin
            if (addr[iop_pkg::IOP_KIND_MSB:iop_pkg::IOP_KIND_LSB] == KIND_OFS[i]) begin
               k = i;
            end
         end
      end
      return k;
   endfunction

   function automatic logic [7:0] pin_mask(input logic [2:0] port);
      logic [7:0] m;
      m = (port == 3'(iop_pkg::IOP_PORT_D)) ? iop_pkg::IOP_D_PIN_MASK
                                            : iop_pkg::IOP_FULL_MASK;
      return m;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   iop_pkg::iop_state_t st_q;
   iop_pkg::iop_state_t st_d;
   logic [2:0]          port;
   logic                port_ok;
   int                  kind;
   logic [7:0]          rd_val;

   assign port    = bus_req.addr[iop_pkg::IOP_PORT_MSB:0];
   assign port_ok = port < 3'(iop_pkg::IOP_PORTS);
   assign kind    = kind_of(bus_req.addr);

   // ************************************************************
   // Pin drivers
   // ************************************************************
   generate
      for (genvar p = 0; p < iop_pkg::IOP_PORTS; p++) begin : g_port
         iop_pin_drive #(
            .HAS_FUNC (iop_pkg::IOP_HAS_FUNC[p]),
            .HAS_OEPT (iop_pkg::IOP_HAS_OEPT[p]),
            .HAS_SLEW (iop_pkg::IOP_HAS_SLEW[p])
         ) u_drive (
            .cfg      (st_q.cfg[p]),
            .oe_term  (oe_term[p]),
            .addr_out (addr_out[p]),
            .pin_ctl  (pin_ctl[p])
         );
      end
   endgenerate

   // ************************************************************
   // Read selection
   // ************************************************************
   always_comb begin
      rd_val = iop_pkg::IOP_UNMAPPED;
      if (port_ok) begin
         case (kind)
            iop_pkg::IOP_RK_FUNC: begin
               if (port_has(iop_pkg::IOP_HAS_FUNC, port)) begin
                  rd_val = st_q.cfg[port].func;
               end
            end
            iop_pkg::IOP_RK_DIR: begin
               rd_val = st_q.cfg[port].dir;
            end
            iop_pkg::IOP_RK_DRIVE: begin
               rd_val = st_q.cfg[port].drive;
            end
            iop_pkg::IOP_RK_DIN: begin
               rd_val = pin_in[port] & pin_mask(port);
            end
            iop_pkg::IOP_RK_DOUT: begin
               rd_val = st_q.cfg[port].latch;
            end
            iop_pkg::IOP_RK_OCELL: begin
               if (port_has(iop_pkg::IOP_HAS_OCELL, port)) begin
                  rd_val = ocell_state[port[0]];
               end
            end
            iop_pkg::IOP_RK_MASK: begin
               if (port_has(iop_pkg::IOP_HAS_OCELL, port)) begin
                  rd_val = st_q.mask[port[0]];
               end
            end
            iop_pkg::IOP_RK_ICELL: begin
               if (port_has(iop_pkg::IOP_HAS_ICELL, port)) begin
                  rd_val = icell_state[port[1:0]];
               end
            end
            iop_pkg::IOP_RK_OESTAT: begin
               if (port_has(iop_pkg::IOP_HAS_OESTAT, port)) begin
                  rd_val = pin_ctl[port].drive_on;
               end
            end
            default: begin
               rd_val = iop_pkg::IOP_UNMAPPED;
            end
         endcase
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_d      = st_q;
      st_d.load = '0;
      if (bus_req.sel && bus_req.rd) begin
         st_d.rdata = rd_val;
      end
      if (bus_req.sel && bus_req.wr && port_ok) begin
         case (kind)
            iop_pkg::IOP_RK_FUNC: begin
               if (port_has(iop_pkg::IOP_HAS_FUNC, port)) begin
                  st_d.cfg[port].func = bus_req.wdata;
               end
            end
            iop_pkg::IOP_RK_DIR: begin
               st_d.cfg[port].dir = bus_req.wdata & pin_mask(port);
            end
            iop_pkg::IOP_RK_DRIVE: begin
               st_d.cfg[port].drive = bus_req.wdata & pin_mask(port);
            end
            iop_pkg::IOP_RK_DOUT: begin
               st_d.cfg[port].latch = bus_req.wdata;
            end
            iop_pkg::IOP_RK_OCELL: begin
               if (port_has(iop_pkg::IOP_HAS_OCELL, port)) begin
                  st_d.load[port[0]] = ~st_q.mask[port[0]];
                  st_d.load_data     = bus_req.wdata;
               end
            end
            iop_pkg::IOP_RK_MASK: begin
               if (port_has(iop_pkg::IOP_HAS_OCELL, port)) begin
                  st_d.mask[port[0]] = bus_req.wdata;
               end
            end
            default: begin
               st_d.load = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q <= iop_pkg::IOP_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus_rdata   = st_q.rdata;
   assign ocell_load  = st_q.load;
   assign ocell_wdata = st_q.load_data;

endmodule

// >>> sim/iop_regs_sva.sv
// Checker for the port register block, bound to its top module
`timescale 1ns/1ns
module iop_regs_sva (
   input logic                        mclk,
   input logic                        rst_n,
   input iop_pkg::iop_bus_req_t       bus_req,
   input logic [7:0]                  bus_rdata,
   input logic [6:0][7:0]             pin_in,
   input logic [6:0][7:0]             oe_term,
   input logic [2:0][7:0]             icell_state,
   input logic [1:0][7:0]             ocell_load,
   input logic [7:0]                  ocell_wdata,
   input iop_pkg::iop_pin_ctl_t [6:0] pin_ctl
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire rd       = bus_req.sel && bus_req.rd;
   wire wr       = bus_req.sel && bus_req.wr;
   wire ocell_wr = wr && (bus_req.addr[7:1] == 7'h14);

   a_oe_merge: assert property ((oe_term[0] & ~pin_ctl[0].drive_on) == 8'h00)
      else $error("Enable term not merged into direction");
   a_d_high_off: assert property (pin_ctl[3].drive_on[7:4] == 4'h0)
      else $error("Upper port D pins active");
   a_od_release: assert property (
      (pin_ctl[0].open_drain & pin_ctl[0].out & pin_ctl[0].oe) == 8'h00)
      else $error("Open drain pin drives high");
   a_oe_needs_dir: assert property ((pin_ctl[6].oe & ~pin_ctl[6].drive_on) == 8'h00)
      else $error("Pin driven while input");
   a_rd_unmapped: assert property (rd && bus_req.addr[7] |=> bus_rdata == 8'h00)
      else $error("Unmapped read not zero");
   a_din_live: assert property (rd && bus_req.addr == 8'h19
      |=> bus_rdata == $past(pin_in[1]))
      else $error("Data in not live pins");
   a_icell_read: assert property (rd && bus_req.addr == 8'h3A
      |=> bus_rdata == $past(icell_state[2]))
      else $error("Input cell readback wrong");
   a_oe_status: assert property (rd && bus_req.addr == 8'h40
      |=> bus_rdata == $past(pin_ctl[0].drive_on))
      else $error("Enable status wrong");
   a_load_cause: assert property (!$past(ocell_wr)
      |-> ocell_load == 16'h0000)
      else $error("Output cell load without write");
   a_load_data: assert property (wr && bus_req.addr == 8'h28
      |=> ocell_wdata == $past(bus_req.wdata))
      else $error("Output cell data wrong");
endmodule

// >>> sim/iop_pin_model.sv
// Pin and output cell model on the far side of the port block
`timescale 1ns/1ns
module iop_pin_model (
   input  logic                        mclk,
   input  logic                        rst_n,
   input  logic [6:0][7:0]             ext,
   input  iop_pkg::iop_pin_ctl_t [6:0] pin_ctl,
   input  logic [1:0][7:0]             ocell_load,
   input  logic [7:0]                  ocell_wdata,
   output logic [6:0][7:0]             pin_in,
   output logic [1:0][7:0]             ocell_state
);
   // Released pins follow the outside level
   always_comb begin
      for (int p = 0; p < 7; p++) begin
         pin_in[p] = (pin_ctl[p].oe & pin_ctl[p].out) | (~pin_ctl[p].oe & ext[p]);
      end
   end
   always @(posedge mclk) begin
      for (int c = 0; c < 2; c++) begin
         if (!rst_n) begin
            ocell_state[c] <= 8'h00;
         end else begin
            ocell_state[c] <= (ocell_load[c] & ocell_wdata) | (~ocell_load[c] & ocell_state[c]);
         end
      end
   end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the port configuration and data registers
`timescale 1ns/1ns
module tb_top;
   logic                        mclk        = 1'b0;
   logic                        rst_n       = 1'b0;
   iop_pkg::iop_bus_req_t       bus_req     = '0;
   logic [6:0][7:0]             oe_term     = '0;
   logic [6:0][7:0]             addr_out    = '0;
   logic [6:0][7:0]             ext         = {7{8'hFF}};
   logic [2:0][7:0]             icell_state = {8'h33, 8'h22, 8'h11};
   logic [7:0]                  bus_rdata;
   logic [6:0][7:0]             pin_in;
   logic [1:0][7:0]             ocell_state;
   logic [1:0][7:0]             ocell_load;
   logic [7:0]                  ocell_wdata;
   iop_pkg::iop_pin_ctl_t [6:0] pin_ctl;
   int                          fail_count  = 0;
   int                          checks      = 0;

   always #20 mclk = ~mclk;

   iop_port_regs i_dut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .pin_in(pin_in), .oe_term(oe_term), .addr_out(addr_out), .ocell_state(ocell_state),
      .icell_state(icell_state), .ocell_load(ocell_load), .ocell_wdata(ocell_wdata),
      .pin_ctl(pin_ctl));
   iop_pin_model i_pin (.mclk(mclk), .rst_n(rst_n), .ext(ext), .pin_ctl(pin_ctl),
      .ocell_load(ocell_load), .ocell_wdata(ocell_wdata), .pin_in(pin_in),
      .ocell_state(ocell_state));

   function automatic logic [7:0] ad(input int k, input int p);
      ad = {1'b0, k[3:0], p[2:0]};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus cycle; a read compares the returned byte
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      bus_req = '{1'b1, w, ~w, a, d};
      @(negedge mclk);
      bus_req = '0;
      if (!w) chk(bus_rdata, d);
   endtask

   task automatic t_reset;
      for (int p = 0; p < 7; p++) begin
         for (int k = 0; k < 3; k++) begin
            acc(1'b0, ad(k, p), 8'h00);
         end
      end
      acc(1'b0, ad(6, 0), 8'h00);
      acc(1'b0, ad(6, 1), 8'h00);
   endtask

   task automatic t_func;
      addr_out[4] = 8'h5C;
      acc(1'b1, ad(1, 4), 8'hFF);
      acc(1'b1, ad(4, 4), 8'hA0);
      acc(1'b1, ad(0, 4), 8'h0F);
      chk(pin_ctl[4].out, 8'hAC);
      chk(pin_ctl[4].oe, 8'hFF);
      acc(1'b0, ad(0, 4), 8'h0F);
      acc(1'b1, ad(0, 0), 8'hFF);
      acc(1'b0, ad(0, 0), 8'h00);
   endtask

   task automatic t_dir;
      oe_term[0] = 8'h30;
      oe_term[3] = 8'hFF;
      oe_term[5] = 8'hC0;
      oe_term[6] = 8'hFF;
      acc(1'b1, ad(1, 0), 8'h07);
      chk(pin_ctl[0].drive_on, 8'h37);
      chk(pin_ctl[0].oe, 8'h37);
      chk(pin_ctl[5].drive_on, 8'hC0);
      chk(pin_ctl[6].drive_on, 8'h00);
      acc(1'b0, ad(8, 0), 8'h37);
      acc(1'b0, ad(8, 5), 8'hC0);
      acc(1'b0, ad(1, 0), 8'h07);
      acc(1'b1, ad(1, 3), 8'hFF);
      acc(1'b0, ad(1, 3), 8'h0F);
      chk(pin_ctl[3].drive_on, 8'h0F);
      oe_term = '0;
   endtask

   task automatic t_drive;
      acc(1'b1, ad(2, 0), 8'hFF);
      acc(1'b1, ad(1, 0), 8'hFF);
      acc(1'b1, ad(4, 0), 8'h0F);
      chk(pin_ctl[0].oe, 8'hF0);
      chk(pin_ctl[0].open_drain, 8'hFF);
      acc(1'b0, ad(3, 0), 8'h0F);
      acc(1'b1, ad(2, 2), 8'h81);
      chk(pin_ctl[2].fast_slew, 8'h81);
      chk(pin_ctl[2].open_drain, 8'h00);
      acc(1'b1, ad(2, 5), 8'h0F);
      chk(pin_ctl[5].fast_slew, 8'h0F);
      acc(1'b1, ad(2, 3), 8'hFF);
      acc(1'b0, ad(2, 3), 8'h0F);
   endtask

   task automatic t_data;
      ext[1] = 8'h3C;
      acc(1'b0, ad(3, 1), 8'h3C);
      acc(1'b1, ad(1, 1), 8'hFF);
      acc(1'b1, ad(4, 1), 8'h5A);
      chk(pin_ctl[1].out, 8'h5A);
      acc(1'b0, ad(4, 1), 8'h5A);
      acc(1'b1, ad(3, 1), 8'hFF);
      acc(1'b0, ad(3, 1), 8'h5A);
   endtask

   task automatic t_cell;
      acc(1'b1, ad(6, 0), 8'hF0);
      acc(1'b0, ad(6, 0), 8'hF0);
      acc(1'b1, ad(5, 0), 8'h3C);
      acc(1'b0, ad(5, 0), 8'h0C);
      acc(1'b1, ad(5, 1), 8'hA5);
      acc(1'b0, ad(5, 1), 8'hA5);
      acc(1'b1, ad(7, 2), 8'hFF);
      acc(1'b0, ad(7, 2), 8'h33);
      acc(1'b0, ad(7, 3), 8'h00);
      acc(1'b0, 8'h80, 8'h00);
   endtask

   // Mid-run reset clears configuration and mask again
   task automatic t_rerst;
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      chk(pin_ctl[0].oe, 8'h00);
      chk(pin_ctl[4].out, 8'h00);
      acc(1'b0, ad(1, 0), 8'h00);
      acc(1'b0, ad(2, 0), 8'h00);
      acc(1'b0, ad(0, 4), 8'h00);
      acc(1'b0, ad(6, 0), 8'h00);
   endtask

   task final_report;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      t_reset;
      t_func;
      t_dir;
      t_drive;
      t_data;
      t_cell;
      t_rerst;
      final_report;
   end

   initial begin
      #400000;
      fail_count++;
      final_report;
   end
endmodule

bind iop_port_regs iop_regs_sva i_sva (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .pin_in(pin_in), .oe_term(oe_term), .icell_state(icell_state),
   .ocell_load(ocell_load), .ocell_wdata(ocell_wdata), .pin_ctl(pin_ctl));
